/* nrps_sequencer.sv */
// control pin decoder, start-up sequencer and fault latch
`timescale 1ns/100ps
`include "nrps_cfg.svh"

// Overview of operation
// - pin high enables, pin low shuts down
// - start negative rail at default code zero
// - count rising edges, code 1..31 sets level
// - host pulses between 2 and 25 us
// - first ramp fast, later ramps slew-limited
// - positive soft-start, negative starts after 10 ms
// - run-time rail short over 3 ms faults
// - fault latches both converters off
// - pin low then high clears fault
// - start-up checks at 10 and 20 ms
// - discharge both rails while shut down
// - over-temperature shuts down and latches
// - start only with supply above lockout
module nrps_sequencer #(
    parameter int INIT_CYC = `NRPS_INIT_CYC,
    parameter int OFF_CYC = `NRPS_OFF_CYC,
    parameter int STORE_CYC = `NRPS_STORE_CYC,
    parameter int MS_CYC = `NRPS_MS_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ctrlPin,
    input wire nrps_pkg::nrps_sense_t sense,
    output nrps_pkg::nrps_ctrl_t ctrl
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        nrps_pkg::nrps_state_t state;
        logic pinLast;             // previous pin sample
        logic [31:0] lowCnt;       // cycles the pin has been low
        logic [31:0] sinceEn;      // cycles since enable
        logic [31:0] shortCnt;     // run-time short duration
        logic [31:0] storeCnt;     // quiet time before code store
        logic [4:0] edgeCnt;       // edges seen in this burst
        logic storePend;           // burst waiting to be stored
        logic firstDone;           // first ramp finished
        nrps_pkg::nrps_ctrl_t out; // registered outputs
    } nrps_regs_t;

    nrps_regs_t r;
    nrps_regs_t next_r;

    // saturating increment used by all timers
    function automatic logic [31:0] incSat(input logic [31:0] v);
        incSat = (v == 32'hffffffff) ? v : v + 32'h00000001;
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic rise;
        logic longLow;
        logic runShort;
        rise = 1'b0;
        longLow = 1'b0;
        runShort = 1'b0;
        next_r = r;
        // a rise while off or in fault is never counted
        rise = ctrlPin && !r.pinLast;
        next_r.pinLast = ctrlPin;
        // low time; long low means disable
        next_r.lowCnt = ctrlPin ? 32'h00000000 : incSat(r.lowCnt);
        longLow = !ctrlPin && (r.lowCnt >= 32'(OFF_CYC));
        next_r.sinceEn = incSat(r.sinceEn);
        case (r.state)
            nrps_pkg::NRPS_OFF: begin
                next_r.sinceEn = 32'h00000000;
                next_r.edgeCnt = `NRPS_CODE_DEFAULT;
                next_r.storePend = 1'b0;
                next_r.firstDone = 1'b0;
                next_r.out.negCode = `NRPS_CODE_DEFAULT;
                // start only on supply ok with pin high
                if (ctrlPin && sense.supplyOk && !sense.overTemp) begin
                    next_r.state = nrps_pkg::NRPS_POS_START;
                end
            end
            nrps_pkg::NRPS_POS_START, nrps_pkg::NRPS_NEG_START,
            nrps_pkg::NRPS_RUN: begin
                // edge counting after init interval
                if (rise && r.sinceEn >= 32'(INIT_CYC)) begin
                    if (r.edgeCnt != `NRPS_CODE_MAX) begin
                        next_r.edgeCnt = r.edgeCnt + 5'h01;
                    end
                    next_r.storePend = 1'b1;
                    next_r.storeCnt = 32'h00000000;
                end else if (r.storePend && ctrlPin) begin
                    next_r.storeCnt = incSat(r.storeCnt);
                    // store code after a quiet high interval
                    if (r.storeCnt >= 32'(STORE_CYC)) begin
                        next_r.out.negCode = r.edgeCnt;
                        next_r.edgeCnt = `NRPS_CODE_DEFAULT;
                        next_r.storePend = 1'b0;
                    end
                end
                // start-up timing and checks
                if (r.state == nrps_pkg::NRPS_POS_START &&
                        r.sinceEn >= 32'(`NRPS_NEG_START_MS * MS_CYC)) begin
                    if (!sense.posInReg || sense.negAboveStartThr) begin
                        next_r.state = nrps_pkg::NRPS_FAULT;
                    end else begin
                        next_r.state = nrps_pkg::NRPS_NEG_START;
                    end
                end
                if (r.state == nrps_pkg::NRPS_NEG_START) begin
                    if (sense.negInReg) begin
                        next_r.state = nrps_pkg::NRPS_RUN;
                        next_r.firstDone = 1'b1;
                    end else if (r.sinceEn >= 32'(`NRPS_NEG_CHECK_MS * MS_CYC)) begin
                        next_r.state = nrps_pkg::NRPS_FAULT;
                    end
                end
                // run-time short timer
                runShort = !sense.posInReg || sense.negAboveRunThr;
                if (r.state == nrps_pkg::NRPS_RUN && runShort) begin
                    next_r.shortCnt = incSat(r.shortCnt);
                    if (r.shortCnt >= 32'(`NRPS_RUN_SHORT_MS * MS_CYC)) begin
                        next_r.state = nrps_pkg::NRPS_FAULT;
                    end
                end else begin
                    next_r.shortCnt = 32'h00000000;
                end
                if (sense.overTemp) begin
                    next_r.state = nrps_pkg::NRPS_FAULT;
                end
                if (longLow || !sense.supplyOk) begin
                    next_r.state = nrps_pkg::NRPS_OFF;
                end
            end
            nrps_pkg::NRPS_FAULT: begin
                // latched until pin low long enough or supply drop
                if (longLow || !sense.supplyOk) begin
                    next_r.state = nrps_pkg::NRPS_OFF;
                end
            end
            default: begin
                next_r.state = nrps_pkg::NRPS_OFF;
            end
        endcase
        // converter controls from the next state
        next_r.out.posEnable = next_r.state inside {nrps_pkg::NRPS_POS_START,
            nrps_pkg::NRPS_NEG_START, nrps_pkg::NRPS_RUN};
        next_r.out.posSoftLimit = next_r.state == nrps_pkg::NRPS_POS_START;
        next_r.out.negEnable = next_r.state inside {nrps_pkg::NRPS_NEG_START,
            nrps_pkg::NRPS_RUN};
        next_r.out.negFastRamp = next_r.out.negEnable && !next_r.firstDone;
        next_r.out.posDischarge = !next_r.out.posEnable;
        next_r.out.negDischarge = !next_r.out.negEnable;
        next_r.out.faultLatched = next_r.state == nrps_pkg::NRPS_FAULT;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.state <= nrps_pkg::NRPS_OFF;
            // both rails discharge from reset onward
            r.out.posDischarge <= 1'b1;
            r.out.negDischarge <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign ctrl = r.out;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence sEnter;
        $rose(ctrl.posEnable);
    endsequence

    a_no_neg_early: assert property (sEnter |-> !ctrl.negEnable [*8])
        else $error("negative converter started with positive");
    a_soft_limit: assert property (ctrl.negEnable |-> !ctrl.posSoftLimit)
        else $error("soft limit held after negative start");
    a_fault_off: assert property (ctrl.faultLatched |-> !ctrl.posEnable && !ctrl.negEnable)
        else $error("converter on during fault");
    a_discharge_off: assert property (!ctrl.posEnable |-> ctrl.posDischarge && ctrl.negDischarge)
        else $error("no discharge in shutdown");
    a_lockout_start: assert property (sEnter |-> $past(sense.supplyOk))
        else $error("start without supply ok");
    a_pin_start: assert property (sEnter |-> $past(ctrlPin))
        else $error("start without pin high");
    a_temp_stop: assert property (sense.overTemp && ctrl.posEnable |=> !ctrl.posEnable)
        else $error("over-temperature ignored");
    a_default_code: assert property (sEnter |-> ctrl.negCode == `NRPS_CODE_DEFAULT)
        else $error("start not at default code");
    // a supply cycle may clear the fault even with the pin high
    a_fault_held: assert property (ctrl.faultLatched && ctrlPin && sense.supplyOk
        |=> ctrl.faultLatched)
        else $error("fault left while pin high");
    a_fast_first: assert property ($rose(ctrl.negEnable) |-> ctrl.negFastRamp)
        else $error("first ramp not fast");
    // once the first level is reached, later moves stay slew-limited
    a_slow_later: assert property (ctrl.negEnable && !ctrl.negFastRamp
        |=> !ctrl.negFastRamp)
        else $error("fast ramp after first level");
    // a stored code is never the default, which only the off state restores
    a_code_store: assert property ($changed(ctrl.negCode) && ctrl.posEnable
        |-> ctrl.negCode != `NRPS_CODE_DEFAULT)
        else $error("code went to default while on");

    // converters running when the supply falls below lockout
    sequence sSupplyLost;
        ctrl.posEnable && !sense.supplyOk;
    endsequence

    a_supply_drop: assert property (sSupplyLost |=> !ctrl.posEnable)
        else $error("converter kept on without supply");
    a_lockout_hold: assert property (!ctrl.posEnable && !sense.supplyOk
        |=> !ctrl.posEnable)
        else $error("start below lockout");
endmodule

/* nrps_cfg.svh */
// timing constants and fixed codes of the negative rail pulse sequencer
`ifndef NRPS_CFG_SVH
`define NRPS_CFG_SVH
// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define NRPS_CLK_MHZ 125
// ---------------------------------------------------------------
// times, as printed, in their own units
// ---------------------------------------------------------------
`define NRPS_INIT_US 400
`define NRPS_OFF_US 80
`define NRPS_STORE_US 80
`define NRPS_NEG_START_MS 10
`define NRPS_POS_CHECK_MS 10
`define NRPS_NEG_CHECK_MS 20
`define NRPS_RUN_SHORT_MS 3
// ---------------------------------------------------------------
// derived cycle counts
// ---------------------------------------------------------------
`define NRPS_INIT_CYC (`NRPS_INIT_US * `NRPS_CLK_MHZ)
`define NRPS_OFF_CYC (`NRPS_OFF_US * `NRPS_CLK_MHZ)
`define NRPS_STORE_CYC (`NRPS_STORE_US * `NRPS_CLK_MHZ)
`define NRPS_MS_CYC (1000 * `NRPS_CLK_MHZ)
// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define NRPS_CODE_DEFAULT 5'h00
`define NRPS_CODE_MAX 5'h1f
`endif

/* nrps_pkg.sv */
// types of the negative rail pulse sequencer
package nrps_pkg;
    // sequencer states, gray along the start-up path
    typedef enum logic [2:0] {
        NRPS_OFF = 3'b000,
        NRPS_POS_START = 3'b001,
        NRPS_NEG_START = 3'b011,
        NRPS_RUN = 3'b010,
        NRPS_FAULT = 3'b110
    } nrps_state_t;

    // analog comparator and monitor inputs
    typedef struct packed {
        logic supplyOk;
        logic overTemp;
        logic posInReg;
        logic negInReg;
        logic negAboveStartThr;
        logic negAboveRunThr;
    } nrps_sense_t;

    // converter control outputs
    typedef struct packed {
        logic posEnable;
        logic posSoftLimit;
        logic negEnable;
        logic negFastRamp;
        logic posDischarge;
        logic negDischarge;
        logic [4:0] negCode;
        logic faultLatched;
    } nrps_ctrl_t;
endpackage

/* nrps_host_model.sv */
// host controller model that drives the control pin
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host pin driver
// ---------------------------------------------------------------
module nrps_host_model (
    input wire logic clock,
    output logic ctrlPin
);
    // pin low until the host enables the device
    initial ctrlPin = 1'b0;
    // hold a level for n cycles, launched just after an edge
    task automatic hold(input logic lvl, input int n);
        ctrlPin <= lvl;
        repeat (n) @(posedge clock);
    endtask
    // n pulses, each low then high, phases 4..10 cycles
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            hold(1'b0, 4 + $urandom_range(6));
            hold(1'b1, 4 + $urandom_range(6));
        end
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the negative rail pulse sequencer
`timescale 1ns/100ps
module testbench;
    // ---------------------------------------------------------------
    // signals and bookkeeping
    // ---------------------------------------------------------------
    logic clock;
    logic rst_n;
    logic ctrlPin;
    nrps_pkg::nrps_sense_t sense;
    nrps_pkg::nrps_ctrl_t ctrl;
    logic [4:0] codeQ[$]; // expected stored codes
    logic [4:0] lastCode = 5'h00;
    logic [7:0] badStart[3] = '{8'h20, 8'h2a, 8'h28}; // pos low, neg high, neg unregulated
    int ns[4] = '{3, 1, 35, 0}; // burst lengths, last one random
    int fails = 0;
    int checksDone = 0;
    int cycles = 0;
    // ---------------------------------------------------------------
    // parts: host model and design, short counts for simulation
    // ---------------------------------------------------------------
    nrps_host_model u_host (.clock(clock), .ctrlPin(ctrlPin));
    nrps_sequencer #(.INIT_CYC(20), .OFF_CYC(12), .STORE_CYC(12), .MS_CYC(10)) u_dut (
        .clock(clock), .rst_n(rst_n), .ctrlPin(ctrlPin), .sense(sense), .ctrl(ctrl));
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ---------------------------------------------------------------
    // compare and closing tasks
    // ---------------------------------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_code(input logic [4:0] got, input logic [4:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: code %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("counts: %0d checks, %0d mismatches", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // disable long enough to count as shutdown, then start with good rails
    task automatic restart();
        u_host.hold(1'b0, 20);
        check_bit(ctrl.posEnable, 1'b0);
        sense <= 6'b101000;
        u_host.hold(1'b1, 110);
        check_bit(ctrl.faultLatched, 1'b0);
        check_bit(ctrl.negEnable, 1'b1);
        check_code(ctrl.negCode, 5'h00);
        sense <= 6'b101100;
        repeat (3) @(posedge clock);
    endtask
    // ---------------------------------------------------------------
    // monitor: each new nonzero code takes the oldest note
    // ---------------------------------------------------------------
    always @(posedge clock) begin
        if (ctrl.negCode !== lastCode && ctrl.negCode !== 5'h00) begin
            if (codeQ.size() == 0) check_code(ctrl.negCode, 5'h00);
            else check_code(ctrl.negCode, codeQ.pop_front());
        end
        lastCode <= ctrl.negCode;
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            wrap_up();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        sense = 6'b000000;
        void'($urandom(14));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        check_bit(ctrl.posDischarge & ctrl.negDischarge, 1'b1);
        // pin high but supply locked out
        u_host.hold(1'b1, 10);
        check_bit(ctrl.posEnable, 1'b0);
        sense <= 6'b101000;
        repeat (3) @(posedge clock);
        check_bit(ctrl.posEnable & ctrl.posSoftLimit, 1'b1);
        check_bit(ctrl.posDischarge, 1'b0);
        // edges inside the init interval are ignored
        for (int i = 0; i < 2; i++) begin
            u_host.hold(1'b0, 2);
            u_host.hold(1'b1, 2);
        end
        repeat (84) @(posedge clock);
        check_bit(ctrl.negEnable, 1'b0);
        repeat (15) @(posedge clock);
        check_bit(ctrl.negEnable & ctrl.negFastRamp, 1'b1);
        check_bit(ctrl.posSoftLimit, 1'b0);
        check_code(ctrl.negCode, 5'h00);
        sense <= 6'b101100;
        repeat (3) @(posedge clock);
        check_bit(ctrl.negFastRamp, 1'b0);
        $display("test startup done");
        // programming bursts, one saturating
        ns[3] = 4 + $urandom_range(26);
        foreach (ns[i]) begin
            codeQ.push_back(ns[i] > 31 ? 5'h1f : 5'(ns[i]));
            u_host.burst(ns[i]);
            u_host.hold(1'b1, 20);
        end
        check_bit(codeQ.size() == 0, 1'b1);
        $display("test programming done");
        // short rail excursion tolerated, long one latches
        sense.negAboveRunThr <= 1'b1;
        repeat (20) @(posedge clock);
        sense.negAboveRunThr <= 1'b0;
        repeat (2) @(posedge clock);
        check_bit(ctrl.faultLatched, 1'b0);
        sense.negAboveRunThr <= 1'b1;
        repeat (40) @(posedge clock);
        check_bit(ctrl.faultLatched, 1'b1);
        check_bit(ctrl.posEnable | ctrl.negEnable, 1'b0);
        check_bit(ctrl.posDischarge & ctrl.negDischarge, 1'b1);
        restart();
        $display("test run fault done");
        // start-up checks at 10 and 20 ms
        foreach (badStart[i]) begin
            u_host.hold(1'b0, 20);
            sense <= badStart[i][5:0];
            u_host.hold(1'b1, (i == 2) ? 190 : 90);
            check_bit(ctrl.faultLatched, 1'b0);
            repeat (25) @(posedge clock);
            check_bit(ctrl.faultLatched, 1'b1);
        end
        restart();
        $display("test startup faults done");
        // over-temperature, left by a supply cycle with the pin high
        sense.overTemp <= 1'b1;
        repeat (5) @(posedge clock);
        check_bit(ctrl.faultLatched & ~ctrl.posEnable, 1'b1);
        sense <= 6'b001100;
        repeat (3) @(posedge clock);
        check_bit(ctrl.faultLatched | ctrl.posEnable, 1'b0);
        restart();
        // supply drop while running, restart on its return, then disable
        sense.supplyOk <= 1'b0;
        repeat (3) @(posedge clock);
        check_bit(ctrl.posEnable | ctrl.faultLatched, 1'b0);
        sense.supplyOk <= 1'b1;
        repeat (3) @(posedge clock);
        check_bit(ctrl.posEnable & ctrl.posSoftLimit, 1'b1);
        u_host.hold(1'b0, 20);
        check_bit(ctrl.posEnable, 1'b0);
        check_bit(ctrl.negDischarge, 1'b1);
        $display("test shutdown done");
        wrap_up();
    end
endmodule
